// ==== pkg/fpe_pkg.sv ====
/*
 * fpe_pkg: register map, command codes, status codes and timing constants
 * of the flash program/erase controller.
 * Assumes a 32-bit AXI4-Lite register bus, one word per register index.
 */
`default_nettype none
package fpe_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_CTRL = 12'hff8;
	localparam logic [11:0] IDX_SECT = 12'hff9;
	localparam logic [11:0] IDX_KHZ_HI = 12'hffa;
	localparam logic [11:0] IDX_KHZ_LO = 12'hffb;
	localparam int BUS_AW = 14;
	localparam logic [13:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
	localparam logic [13:0] ADDR_SECT = {IDX_SECT, 2'b00};
	localparam logic [13:0] ADDR_KHZ_HI = {IDX_KHZ_HI, 2'b00};
	localparam logic [13:0] ADDR_KHZ_LO = {IDX_KHZ_LO, 2'b00};
	// control register codes
	localparam logic [7:0] CODE_RESET = 8'h00;
	localparam logic [7:0] CODE_UNLOCK1 = 8'h73;
	localparam logic [7:0] CODE_UNLOCK2 = 8'h8c;
	localparam logic [7:0] CODE_SECT_SEL = 8'h5e;
	localparam logic [7:0] CODE_PAGE_ERASE = 8'h95;
	localparam logic [7:0] CODE_MASS_ERASE = 8'h63;
	// controller_state_code values
	localparam logic [5:0] ST_LOCKED = 6'h00;
	localparam logic [5:0] ST_UNL1 = 6'h01;
	localparam logic [5:0] ST_UNL2 = 6'h02;
	localparam logic [5:0] ST_UNLOCKED = 6'h03;
	localparam logic [5:0] ST_SECT = 6'h04;
	localparam logic [5:0] ST_PROG = 6'h08;
	localparam logic [5:0] ST_PERASE = 6'h10;
	localparam logic [5:0] ST_MERASE = 6'h20;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// operation times in microseconds
	localparam logic [15:0] PROG_TIME_US = 16'h0028;
	localparam logic [15:0] PAGE_ERASE_US = 16'h2710;
	localparam logic [15:0] MASS_ERASE_US = 16'h4e20;
	// microsecond tick: one per (kHz/1000) clocks
	localparam logic [16:0] KHZ_PER_MHZ = 17'h0_03e8;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [3:0] {
		FS_LOCKED, FS_UNL1, FS_UNL2, FS_UNLOCKED, FS_SECT,
		FS_PROGEN, FS_PROG, FS_PERASE, FS_MERASE
	} fpe_state_e;
endpackage
`default_nettype wire

// ==== rtl/fpe_timer.sv ====
/*
 * fpe_timer: times one flash operation in microseconds, using the
 * clock frequency in kHz that software loaded.
 * Assumes khz holds the real clock rate; zero ticks every clock.
 */
`timescale 1ns/1ps
`default_nettype none
module fpe_timer (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic [15:0] khz,
	input wire logic start,
	input wire logic [15:0] durUs,
	// status
	output logic busy,
	output logic done
);
	logic [16:0] acc_reg;
	logic [15:0] left_reg;
	logic busy_reg;
	logic usTick;
	logic [16:0] accSum;

	// fractional accumulator avoids a divider by 1000
	assign accSum = acc_reg + fpe_pkg::KHZ_PER_MHZ;
	assign usTick = busy_reg && (accSum >= {1'b0, khz});
	assign busy = busy_reg;
	assign done = busy_reg && usTick && (left_reg <= 16'h0001);

	// accumulator
	always_ff @(posedge clk) begin
		if (srst || start || !busy_reg) begin
			acc_reg <= 17'h0_0000;
		end else if (usTick) begin
			acc_reg <= accSum - {1'b0, khz};
		end else begin
			acc_reg <= accSum;
		end
	end

	// remaining microseconds and busy flag
	always_ff @(posedge clk) begin
		if (srst) begin
			left_reg <= 16'h0000;
			busy_reg <= 1'b0;
		end else if (start) begin
			left_reg <= durUs;
			busy_reg <= 1'b1;
		end else if (done) begin
			busy_reg <= 1'b0;
		end else if (usTick) begin
			left_reg <= left_reg - 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/fpe_controller.sv ====
/*
 * fpe_controller: flash program/erase sequencer with AXI4-Lite registers,
 * two program-write sources and a strobe interface to the flash array.
 * Assumes the array clears only the zero bits of flashWrData while
 * flashProgram is high and erases while an erase level is high.
 */
`timescale 1ns/1ps
`default_nettype none
module fpe_controller #(
	parameter int MEM_AW = 11,
	parameter int PAGE_AW = 9,
	parameter logic [15:0] PROG_US = fpe_pkg::PROG_TIME_US,
	parameter logic [15:0] PERASE_US = fpe_pkg::PAGE_ERASE_US,
	parameter logic [15:0] MERASE_US = fpe_pkg::MASS_ERASE_US
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// AXI4-Lite write
	input wire logic [13:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [13:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// debugger memory write
	input wire logic dbgWrValid,
	output logic dbgWrReady,
	input wire logic [MEM_AW-1:0] dbgWrAddr,
	input wire logic [7:0] dbgWrData,
	// processor program_memory_store / program_memory_store_autoinc
	input wire logic cpuStoreValid,
	output logic cpuStoreReady,
	input wire logic [MEM_AW-1:0] cpuStoreAddr,
	input wire logic [7:0] cpuStoreData,
	output logic cpuHold,
	// flash array
	output logic [MEM_AW-1:0] flashAddr,
	output logic [7:0] flashWrData,
	output logic flashProgram,
	output logic flashPageErase,
	output logic flashMassErase
);
	localparam int PG_W = MEM_AW - PAGE_AW;

	fpe_pkg::fpe_state_e state_reg;
	logic [7:0] sectLock_reg, pageSel_reg, khzHi_reg, khzLo_reg;
	logic massScope_reg;
	logic awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg;
	logic [13:0] awAddr_reg;
	logic [7:0] wByte_reg;
	logic wLane_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [MEM_AW-1:0] flashAddr_reg;
	logic [7:0] flashData_reg;
	logic doWrite, ctrlWr, sectWr, hiWr, loWr, wMapped;
	logic reqValid, reqTake, reqOk, idle, timerStart, timerBusy, timerDone;
	logic [MEM_AW-1:0] reqAddr;
	logic [7:0] reqData, ctrlByte;
	logic [5:0] statusCode;
	logic [15:0] clockKhzValue, durUs;
	logic startProg, startErase, pageLocked;

	// sector of a flash address: top three address bits
	function automatic logic [2:0] sectorOf(input logic [MEM_AW-1:0] a);
		sectorOf = a[MEM_AW-1 -: 3];
	endfunction

	// true if any locked sector overlaps page p; a page spans two sectors
	function automatic logic pageHit(input logic [7:0] lock,
		input logic [PG_W-1:0] p);
		int pLo, sLo;
		pageHit = 1'b0;
		pLo = int'(p) << PAGE_AW;
		for (int s = 0; s < 8; s++) begin
			sLo = s << (MEM_AW - 3);
			if (lock[s] && sLo < pLo + (1 << PAGE_AW)
				&& pLo < sLo + (1 << (MEM_AW - 3))) begin
				pageHit = 1'b1;
			end
		end
	endfunction

	// register decode, shared by read and write paths
	function automatic logic isMapped(input logic [13:0] a);
		isMapped = (a == fpe_pkg::ADDR_CTRL) || (a == fpe_pkg::ADDR_SECT)
			|| (a == fpe_pkg::ADDR_KHZ_HI) || (a == fpe_pkg::ADDR_KHZ_LO);
	endfunction

	// AXI write channels; both must be held before the write acts
	assign awready = !awHeld_reg && !bvalid_reg;
	assign wready = !wHeld_reg && !bvalid_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
	assign wMapped = isMapped(awAddr_reg);
	assign ctrlByte = wByte_reg;
	// a write without lane 0 enabled stores nothing
	assign ctrlWr = doWrite && wLane_reg && awAddr_reg == fpe_pkg::ADDR_CTRL;
	assign sectWr = doWrite && wLane_reg && awAddr_reg == fpe_pkg::ADDR_SECT;
	assign hiWr = doWrite && wLane_reg && awAddr_reg == fpe_pkg::ADDR_KHZ_HI;
	assign loWr = doWrite && wLane_reg && awAddr_reg == fpe_pkg::ADDR_KHZ_LO;

	// write channel capture and response
	always_ff @(posedge clk) begin
		if (srst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= fpe_pkg::RESP_OKAY;
			awAddr_reg <= 14'h0000;
			wByte_reg <= fpe_pkg::RST_BYTE;
			wLane_reg <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld_reg <= 1'b1;
				wByte_reg <= wdata[7:0];
				wLane_reg <= wstrb[0];
			end
			if (doWrite) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wMapped ? fpe_pkg::RESP_OKAY
					: fpe_pkg::RESP_SLVERR;
			end else if (bvalid_reg && bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// read path: status shares the control address
	assign arready = !rvalid_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	always_ff @(posedge clk) begin
		if (srst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= fpe_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= isMapped(araddr) ? fpe_pkg::RESP_OKAY
				: fpe_pkg::RESP_SLVERR;
			case (araddr)
				fpe_pkg::ADDR_CTRL: rdata_reg <= {26'h0, statusCode};
				fpe_pkg::ADDR_SECT: rdata_reg <= {24'h0,
					state_reg == fpe_pkg::FS_SECT ? sectLock_reg : pageSel_reg};
				fpe_pkg::ADDR_KHZ_HI: rdata_reg <= {24'h0, khzHi_reg};
				fpe_pkg::ADDR_KHZ_LO: rdata_reg <= {24'h0, khzLo_reg};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end else if (rvalid_reg && rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// frequency, page select and write-one-set sector protection
	always_ff @(posedge clk) begin
		if (srst) begin
			khzHi_reg <= fpe_pkg::RST_BYTE;
			khzLo_reg <= fpe_pkg::RST_BYTE;
			pageSel_reg <= fpe_pkg::RST_BYTE;
			sectLock_reg <= fpe_pkg::RST_BYTE;
		end else begin
			if (hiWr) khzHi_reg <= ctrlByte;
			if (loWr) khzLo_reg <= ctrlByte;
			if (sectWr && state_reg == fpe_pkg::FS_SECT) begin
				sectLock_reg <= sectLock_reg | ctrlByte;
			end else if (sectWr) begin
				pageSel_reg <= ctrlByte;
			end
		end
	end
	assign clockKhzValue = {khzHi_reg, khzLo_reg};

	// write sources: debugger first, both treated alike
	assign idle = state_reg != fpe_pkg::FS_PROG
		&& state_reg != fpe_pkg::FS_PERASE && state_reg != fpe_pkg::FS_MERASE;
	// a program write waits out a control write in the same cycle
	assign dbgWrReady = idle && !ctrlWr;
	assign cpuStoreReady = idle && !ctrlWr && !dbgWrValid;
	assign reqValid = dbgWrValid || cpuStoreValid;
	assign reqAddr = dbgWrValid ? dbgWrAddr : cpuStoreAddr;
	assign reqData = dbgWrValid ? dbgWrData : cpuStoreData;
	assign reqTake = idle && !ctrlWr && reqValid;
	// refused writes are taken and dropped so the source never hangs
	assign reqOk = state_reg == fpe_pkg::FS_PROGEN
		&& !sectLock_reg[sectorOf(reqAddr)]
		&& (massScope_reg
		|| reqAddr[MEM_AW-1:PAGE_AW] == pageSel_reg[PG_W-1:0]);
	assign startProg = reqTake && reqOk;
	assign pageLocked = pageHit(sectLock_reg, pageSel_reg[PG_W-1:0]);
	// erase starts only where the state machine leaves idle for it
	assign startErase = idle && ctrlWr
		&& (state_reg == fpe_pkg::FS_UNLOCKED
		|| state_reg == fpe_pkg::FS_PROGEN)
		&& ((ctrlByte == fpe_pkg::CODE_PAGE_ERASE && !pageLocked)
		|| (ctrlByte == fpe_pkg::CODE_MASS_ERASE
		&& sectLock_reg == fpe_pkg::RST_BYTE));

	// lock, unlock, select and operation sequencing
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= fpe_pkg::FS_LOCKED;
			massScope_reg <= 1'b0;
		end else if (!idle) begin
			if (timerDone) state_reg <= fpe_pkg::FS_PROGEN;
		end else if (ctrlWr && ctrlByte == fpe_pkg::CODE_SECT_SEL) begin
			state_reg <= fpe_pkg::FS_SECT;
		end else if (ctrlWr) begin
			state_reg <= fpe_pkg::FS_LOCKED;
			case (state_reg)
				fpe_pkg::FS_LOCKED:
					if (ctrlByte == fpe_pkg::CODE_UNLOCK1)
						state_reg <= fpe_pkg::FS_UNL1;
				fpe_pkg::FS_UNL1:
					if (ctrlByte == fpe_pkg::CODE_UNLOCK2)
						state_reg <= fpe_pkg::FS_UNL2;
				fpe_pkg::FS_UNLOCKED, fpe_pkg::FS_PROGEN: begin
					if (ctrlByte == fpe_pkg::CODE_PAGE_ERASE
						&& !pageLocked) begin
						state_reg <= fpe_pkg::FS_PERASE;
						massScope_reg <= 1'b0;
					end
					if (ctrlByte == fpe_pkg::CODE_MASS_ERASE
						&& sectLock_reg == fpe_pkg::RST_BYTE) begin
						state_reg <= fpe_pkg::FS_MERASE;
						massScope_reg <= 1'b1;
					end
				end
				default: state_reg <= fpe_pkg::FS_LOCKED;
			endcase
		end else if (sectWr && state_reg == fpe_pkg::FS_UNL2) begin
			state_reg <= fpe_pkg::FS_UNLOCKED;
		end else if (reqTake && reqOk) begin
			state_reg <= fpe_pkg::FS_PROG;
		end
	end

	// flash address and data latched when an operation starts
	always_ff @(posedge clk) begin
		if (srst) begin
			flashAddr_reg <= '0;
			flashData_reg <= fpe_pkg::ERASED_BYTE;
		end else if (reqTake && reqOk) begin
			flashAddr_reg <= reqAddr;
			flashData_reg <= reqData;
		end else if (idle && ctrlWr) begin
			flashAddr_reg <= {pageSel_reg[PG_W-1:0], {PAGE_AW{1'b0}}};
			flashData_reg <= fpe_pkg::ERASED_BYTE;
		end
	end

	// operation timer, started on the cycle the state leaves idle
	assign timerStart = startProg || startErase;
	assign durUs = startProg ? PROG_US
		: (ctrlByte == fpe_pkg::CODE_MASS_ERASE) ? MERASE_US : PERASE_US;
	fpe_timer u_timer (
		.clk(clk),
		.srst(srst),
		.khz(clockKhzValue),
		.start(timerStart),
		.durUs(durUs),
		.busy(timerBusy),
		.done(timerDone)
	);

	// array strobes and processor stall follow the state
	assign flashProgram = state_reg == fpe_pkg::FS_PROG;
	assign flashPageErase = state_reg == fpe_pkg::FS_PERASE;
	assign flashMassErase = state_reg == fpe_pkg::FS_MERASE;
	assign cpuHold = flashProgram;
	assign flashAddr = flashAddr_reg;
	assign flashWrData = flashData_reg;

	// status code; busy low bits read zero
	always_comb begin
		case (state_reg)
			fpe_pkg::FS_UNL1: statusCode = fpe_pkg::ST_UNL1;
			fpe_pkg::FS_UNL2: statusCode = fpe_pkg::ST_UNL2;
			fpe_pkg::FS_UNLOCKED: statusCode = fpe_pkg::ST_UNLOCKED;
			fpe_pkg::FS_PROGEN: statusCode = fpe_pkg::ST_UNLOCKED;
			fpe_pkg::FS_SECT: statusCode = fpe_pkg::ST_SECT;
			fpe_pkg::FS_PROG: statusCode = fpe_pkg::ST_PROG;
			fpe_pkg::FS_PERASE: statusCode = fpe_pkg::ST_PERASE;
			fpe_pkg::FS_MERASE: statusCode = fpe_pkg::ST_MERASE;
			default: statusCode = fpe_pkg::ST_LOCKED;
		endcase
	end

	// checks
	property p_lockSticky;
		@(posedge clk) disable iff (srst)
		!$past(srst) |-> (sectLock_reg & $past(sectLock_reg))
			== $past(sectLock_reg);
	endproperty
	a_lockSticky: assert property (p_lockSticky)
		else $error("sector lock bit cleared");
	property p_protRefused;
		@(posedge clk) disable iff (srst)
		$rose(flashProgram) |-> !sectLock_reg[sectorOf(flashAddr)];
	endproperty
	a_protRefused: assert property (p_protRefused)
		else $error("protected sector programmed");
	property p_pageScope;
		@(posedge clk) disable iff (srst)
		$rose(flashProgram) && !massScope_reg
			|-> flashAddr[MEM_AW-1:PAGE_AW] == pageSel_reg[PG_W-1:0];
	endproperty
	a_pageScope: assert property (p_pageScope)
		else $error("program outside selected page");
	property p_holdCpu;
		@(posedge clk) disable iff (srst)
		reqTake && reqOk |=> cpuHold && statusCode[5:3] == 3'b001;
	endproperty
	a_holdCpu: assert property (p_holdCpu)
		else $error("processor not held while programming");
	property p_relock;
		@(posedge clk) disable iff (srst)
		ctrlWr && state_reg == fpe_pkg::FS_PROGEN
			&& ctrlByte != fpe_pkg::CODE_PAGE_ERASE
			&& ctrlByte != fpe_pkg::CODE_MASS_ERASE
			&& ctrlByte != fpe_pkg::CODE_SECT_SEL
			|=> statusCode == fpe_pkg::ST_LOCKED;
	endproperty
	a_relock: assert property (p_relock)
		else $error("controller not locked after other write");
	property p_unlock1;
		@(posedge clk) disable iff (srst)
		ctrlWr && ctrlByte == fpe_pkg::CODE_UNLOCK1
			&& statusCode == fpe_pkg::ST_LOCKED
			|=> statusCode == fpe_pkg::ST_UNL1;
	endproperty
	a_unlock1: assert property (p_unlock1)
		else $error("first unlock byte not reflected");
	property p_badUnlock;
		@(posedge clk) disable iff (srst)
		ctrlWr && state_reg == fpe_pkg::FS_UNL1
			&& ctrlByte != fpe_pkg::CODE_UNLOCK2
			&& ctrlByte != fpe_pkg::CODE_SECT_SEL
			|=> statusCode == fpe_pkg::ST_LOCKED;
	endproperty
	a_badUnlock: assert property (p_badUnlock)
		else $error("broken unlock sequence did not relock");
	property p_massCode;
		@(posedge clk) disable iff (srst)
		flashMassErase |-> statusCode[5:3] == 3'b100
			&& flashWrData == fpe_pkg::ERASED_BYTE;
	endproperty
	a_massCode: assert property (p_massCode)
		else $error("mass erase status code wrong");
	property p_deselect;
		@(posedge clk) disable iff (srst)
		ctrlWr && state_reg == fpe_pkg::FS_SECT
			&& ctrlByte != fpe_pkg::CODE_SECT_SEL
			|=> state_reg != fpe_pkg::FS_SECT;
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("sector register still selected");
	property p_statusRead;
		@(posedge clk) disable iff (srst)
		arvalid && arready && araddr == fpe_pkg::ADDR_CTRL
			|=> rvalid && rdata[5:0] == $past(statusCode)
			&& rdata[31:6] == 26'h0;
	endproperty
	a_statusRead: assert property (p_statusRead)
		else $error("status read mismatch");
	property p_opEnds;
		@(posedge clk) disable iff (srst)
		timerDone |=> state_reg == fpe_pkg::FS_PROGEN && !timerBusy;
	endproperty
	a_opEnds: assert property (p_opEnds)
		else $error("operation did not finish");
	c_program: cover property (@(posedge clk) disable iff (srst)
		$fell(flashProgram));
	c_pageErase: cover property (@(posedge clk) disable iff (srst)
		$fell(flashPageErase));
	c_massErase: cover property (@(posedge clk) disable iff (srst)
		$fell(flashMassErase));
	c_sectSet: cover property (@(posedge clk) disable iff (srst)
		sectWr && state_reg == fpe_pkg::FS_SECT && ctrlByte != 8'h00);
endmodule
`default_nettype wire

// ==== sim/fpe_flash_model.sv ====
/*
 * fpe_flash_model: behavioural flash array facing the controller.
 * Assumes level strobes from fpe_controller and a single clock.
 */
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model #(
	parameter int AW = 11,
	parameter int PAW = 9
) (
	// clock
	input wire logic clk,
	// array strobes
	input wire logic [AW-1:0] flashAddr,
	input wire logic [7:0] flashWrData,
	input wire logic flashProgram,
	input wire logic flashPageErase,
	input wire logic flashMassErase
);
	logic [7:0] mem [2**AW];
	// contents before the first erase are arbitrary, all ones only where the low address byte is c3
	initial begin
		for (int i = 0; i < 2**AW; i++) begin
			mem[i] = i[7:0] ^ 8'h3c;
		end
	end
	// erase sets ones; program can only clear bits, never set them
	always @(posedge clk) begin
		if (flashMassErase || flashPageErase) begin
			for (int i = 0; i < 2**AW; i++) begin
				if (flashMassErase || (i >> PAW) == (flashAddr >> PAW)) begin
					mem[i] <= 8'hff;
				end
			end
		end else if (flashProgram) begin
			mem[flashAddr] <= mem[flashAddr] & flashWrData;
		end
	end
endmodule
`default_nettype wire

// ==== sim/tb_flash_program_erase_controller.sv ====
/*
 * tb_flash_program_erase_controller: self-checking bench of fpe_controller.
 * Assumes shortened op times and a 1000 kHz setting (one clock per us).
 */
`timescale 1ns/1ps
`default_nettype none
module tb_flash_program_erase_controller;
	localparam int PR = 8;
	logic clk = 0, srst = 1;
	logic [13:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata, rdv, r;
	logic [3:0] wstrb = 4'hf;
	logic dbgWrValid = 0, cpuStoreValid = 0;
	logic [10:0] dbgWrAddr = 0, cpuStoreAddr = 0, flashAddr;
	logic [7:0] dbgWrData = 0, cpuStoreData = 0, flashWrData;
	logic awready, wready, bvalid, arready, rvalid, cpuHold;
	logic dbgWrReady, cpuStoreReady;
	logic flashProgram, flashPageErase, flashMassErase;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] seed = 32'hd186;
	int n_errors = 0, tests_run = 0, progCnt, holdCnt, peCnt, meCnt;
	int mdl [2048];
	int en = 0, pg = 0, kmul = 1;

	fpe_controller #(.PROG_US(16'h0008), .PERASE_US(16'h000c),
		.MERASE_US(16'h000c)) fpe_controller_inst (
		.clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .dbgWrValid, .dbgWrReady,
		.dbgWrAddr, .dbgWrData, .cpuStoreValid, .cpuStoreReady,
		.cpuStoreAddr, .cpuStoreData, .cpuHold, .flashAddr, .flashWrData,
		.flashProgram, .flashPageErase, .flashMassErase);
	fpe_flash_model fpe_flash_model_inst (.clk, .flashAddr, .flashWrData,
		.flashProgram, .flashPageErase, .flashMassErase);

	// 250 MHz clock
	always #2 clk = ~clk;
	// count strobe cycles on the falling edge, where outputs are settled
	always @(negedge clk) begin
		if (flashProgram) progCnt++;
		if (cpuHold) holdCnt++;
		if (flashPageErase) peCnt++;
		if (flashMassErase) meCnt++;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// write: address and data offered together, each released when taken
	task wr(input logic [13:0] a, input logic [7:0] d);
		logic t1, t2, t3;
		awaddr <= a;
		awvalid <= 1;
		wdata <= {24'h0000_00, d};
		wvalid <= 1;
		bready <= 1;
		for (int n = 0; n < 100; n++) begin
			#1;
			t1 = awvalid && awready;
			t2 = wvalid && wready;
			t3 = bvalid;
			resp = bresp;
			@(posedge clk);
			if (t1) awvalid <= 0;
			if (t2) wvalid <= 0;
			if (t3) break;
		end
		if (!t3) n_errors++;
		bready <= 0;
		@(posedge clk);
	endtask
	task rdreg(input logic [13:0] a);
		logic t1, t3;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (int n = 0; n < 100; n++) begin
			#1;
			t1 = arvalid && arready;
			t3 = rvalid;
			rdv = rdata;
			resp = rresp;
			@(posedge clk);
			if (t1) arvalid <= 0;
			if (t3) break;
		end
		if (!t3) n_errors++;
		rready <= 0;
		@(posedge clk);
	endtask
	task rchk(input logic [13:0] a, input logic [31:0] e);
		rdreg(a);
		chk(rdv, e);
	endtask
	// wait until no strobe to the array is up
	task idle;
		repeat (2) @(posedge clk);
		for (int n = 0; n < 300; n++) begin
			#1;
			if (!(flashProgram || flashPageErase || flashMassErase)) break;
			@(posedge clk);
		end
		if (flashProgram || flashPageErase || flashMassErase) n_errors++;
		@(posedge clk);
	endtask
	// program one byte from either source; rs reads status mid-program
	task pw(input int src, input logic [10:0] a, input logic [7:0] d,
		input bit rs);
		logic t;
		int ok, lo;
		ok = en == 1 || (en == 2 && a[10:9] == pg);
		lo = PR * kmul;
		progCnt = 0;
		holdCnt = 0;
		dbgWrAddr <= a;
		dbgWrData <= d;
		cpuStoreAddr <= a;
		cpuStoreData <= d;
		if (src) cpuStoreValid <= 1;
		else dbgWrValid <= 1;
		for (int n = 0; n < 300; n++) begin
			#1;
			t = src ? cpuStoreValid && cpuStoreReady : dbgWrValid && dbgWrReady;
			@(posedge clk);
			if (t) break;
		end
		if (!t) n_errors++;
		cpuStoreValid <= 0;
		dbgWrValid <= 0;
		if (rs) rchk(fpe_pkg::ADDR_CTRL, fpe_pkg::ST_PROG);
		idle();
		if (ok) mdl[a] = mdl[a] & d;
		chk(32'(ok ? progCnt >= lo - 1 && progCnt <= lo + 2 : progCnt == 0),
			1);
		chk(holdCnt, progCnt);
		chk(fpe_flash_model_inst.mem[a], mdl[a]);
	endtask
	task unl(input int p);
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_RESET);
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_UNLOCK1);
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_UNLOCK2);
		wr(fpe_pkg::ADDR_SECT, p[7:0]);
		en = 0;
		pg = p;
	endtask
	task erase(input logic [7:0] code, input int ok);
		logic m;
		m = code == fpe_pkg::CODE_MASS_ERASE;
		peCnt = 0;
		meCnt = 0;
		wr(fpe_pkg::ADDR_CTRL, code);
		rchk(fpe_pkg::ADDR_CTRL, !ok ? fpe_pkg::ST_LOCKED :
			m ? fpe_pkg::ST_MERASE : fpe_pkg::ST_PERASE);
		idle();
		chk(32'(meCnt > 0), ok && m);
		chk(32'(peCnt > 0), ok && !m);
		en = !ok ? 0 : m ? 1 : 2;
		for (int i = 0; i < 2048; i++) begin
			if (en == 1 || (en == 2 && i / 512 == pg)) mdl[i] = 255;
		end
	endtask

	// main sequence
	initial begin
		// bench copy of the array's power-up contents
		for (int i = 0; i < 2048; i++) mdl[i] = i[7:0] ^ 8'h3c;
		repeat (3) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		rchk(fpe_pkg::ADDR_CTRL, fpe_pkg::ST_LOCKED);
		// a write without lane 0 stores nothing
		wstrb <= 4'he;
		wr(fpe_pkg::ADDR_KHZ_HI, 8'h55);
		wstrb <= 4'hf;
		chk(resp, fpe_pkg::RESP_OKAY);
		rchk(fpe_pkg::ADDR_KHZ_HI, 0);
		rdreg(14'h0000);
		chk(resp, fpe_pkg::RESP_SLVERR);
		wr(14'h0010, 8'h01);
		chk(resp, fpe_pkg::RESP_SLVERR);
		wr(fpe_pkg::ADDR_KHZ_HI, 8'h03);
		wr(fpe_pkg::ADDR_KHZ_LO, 8'he8);
		rchk(fpe_pkg::ADDR_KHZ_HI, 8'h03);
		rchk(fpe_pkg::ADDR_KHZ_LO, 8'he8);
		pw(0, 11'h010, 8'h00, 0);
		// unlock steps read back one by one
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_UNLOCK1);
		rchk(fpe_pkg::ADDR_CTRL, fpe_pkg::ST_UNL1);
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_UNLOCK2);
		rchk(fpe_pkg::ADDR_CTRL, fpe_pkg::ST_UNL2);
		wr(fpe_pkg::ADDR_SECT, 8'h00);
		rchk(fpe_pkg::ADDR_CTRL, fpe_pkg::ST_UNLOCKED);
		// a first unlock byte written while already unlocked relocks
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_UNLOCK1);
		wr(fpe_pkg::ADDR_CTRL, 8'h55);
		rchk(fpe_pkg::ADDR_CTRL, fpe_pkg::ST_LOCKED);
		unl(0);
		erase(fpe_pkg::CODE_MASS_ERASE, 1);
		// each byte programmed at most twice between erases
		for (int i = 0; i < 6; i++) begin
			r = xs();
			pw(i % 2, 11'(i * 256) | 11'(r[7:0]), r[15:8], i == 0);
			pw(1 - i % 2, 11'(i * 256) | 11'(r[7:0]), r[23:16], 0);
		end
		// doubling the kHz value doubles the program time
		wr(fpe_pkg::ADDR_KHZ_HI, 8'h07);
		wr(fpe_pkg::ADDR_KHZ_LO, 8'hd0);
		kmul = 2;
		pw(0, 11'h7ff, 8'h0f, 0);
		wr(fpe_pkg::ADDR_KHZ_HI, 8'h03);
		wr(fpe_pkg::ADDR_KHZ_LO, 8'he8);
		kmul = 1;
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_RESET);
		en = 0;
		rchk(fpe_pkg::ADDR_CTRL, fpe_pkg::ST_LOCKED);
		pw(1, 11'h040, 8'h00, 0);
		// page erase opens its page only
		unl(3);
		erase(fpe_pkg::CODE_PAGE_ERASE, 1);
		pw(0, 11'h650, 8'(xs()), 0);
		pw(1, 11'h250, 8'h00, 0);
		// sector lock: set only, kept across deselect
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_RESET);
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_SECT_SEL);
		rchk(fpe_pkg::ADDR_CTRL, fpe_pkg::ST_SECT);
		rchk(fpe_pkg::ADDR_SECT, 8'h00);
		wr(fpe_pkg::ADDR_SECT, 8'h41);
		wr(fpe_pkg::ADDR_SECT, 8'h00);
		rchk(fpe_pkg::ADDR_SECT, 8'h41);
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_RESET);
		rchk(fpe_pkg::ADDR_CTRL, fpe_pkg::ST_LOCKED);
		wr(fpe_pkg::ADDR_SECT, 8'h02);
		rchk(fpe_pkg::ADDR_SECT, 8'h02);
		wr(fpe_pkg::ADDR_CTRL, fpe_pkg::CODE_SECT_SEL);
		rchk(fpe_pkg::ADDR_SECT, 8'h41);
		unl(3);
		erase(fpe_pkg::CODE_PAGE_ERASE, 0);
		unl(0);
		erase(fpe_pkg::CODE_MASS_ERASE, 0);
		unl(1);
		erase(fpe_pkg::CODE_PAGE_ERASE, 1);
		close_out();
	end
	// watchdog against a hung handshake
	initial begin
		#100000;
		n_errors++;
		close_out();
	end
endmodule
`default_nettype wire
